/* hdl/unbi_irq.v */
// USB NAK and bus-event interrupt block: enables, sticky requests, PING and
// IN-NAK handshake decisions, line-state watch for bus reset and suspend.
// Assumes token strobes come from the serial interface engine on aclk, and
// that the raw D+/D- levels arrive asynchronously from the transceiver.
//
// Behaviour
// - Ping-NAK bits 7..2 serve endpoints 8,6,4,2,1,0; active only at high speed.
// - PING to an OUT endpoint without free buffer is answered NAK, repeatedly.
// - Once a buffer is free the next PING is answered ACK.
// - Set endpoint ping-NAK request when OUT attempt is NAKed for lack of buffer.
// - Set summary IN-bulk-NAK bit 0 when an unarmed bulk IN endpoint NAKs.
// - Summary request fires only on a rise of the enabled per-endpoint OR.
// - IN token to unarmed bulk IN endpoint is NAKed and sets its request bit.
// - Writing one clears a request bit; writing zero leaves it alone.
// - Request bits other than summary bit 0 set and hold whatever the enable bits say.
// - Bit 6 sets when the endpoint-zero status stage completes.
// - Bit 5 sets when high-speed operation is granted.
// - Bit 4 sets at the onset of a bus reset (both lines low).
// - Bit 3 sets after three milliseconds without bus activity.
// - Bit 2 sets on every received SETUP token.
// - Bit 1 sets on every received start-of-frame packet.
// - Bit 0 sets once all eight SETUP bytes reach the setup registers.
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "unbi_map.vh"

module unbi_irq #(
  parameter SUSPEND_CYC = `UNBI_SUSPEND_CYC,
  parameter RESET_ONSET_CYC = `UNBI_RESET_ONSET_CYC
)
(
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite slave.
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Serial interface engine side, all on aclk.
  input wire high_speed,
  input wire ping_tok,
  input wire out_tok,
  input wire [2:0] out_ep,
  input wire [5:0] out_buf_free,
  input wire in_tok,
  input wire [2:0] in_ep,
  input wire [5:0] in_ep_armed,
  input wire ctrl_status_done,
  input wire hs_grant,
  input wire setup_tok,
  input wire sof_pkt,
  input wire setup_bytes_stored,
  // Raw bus line levels, asynchronous.
  input wire usb_dp,
  input wire usb_dm,
  // Handshake decisions and the shared interrupt.
  output reg hs_ack,
  output reg hs_nak,
  output reg usb_interrupt_line
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [7:0] ping_nak_in_nak_enable_r;
  reg [7:0] ping_nak_in_nak_request_r;
  reg [7:0] bus_event_enable_r;
  reg [7:0] bus_event_request_r;
  reg [7:0] per_endpoint_in_nak_enable_r;
  reg [7:0] per_endpoint_in_nak_request_r;
  reg in_nak_or_prev_r;

  // Line-state synchronisers and counters.
  reg [1:0] line_meta_r;
  reg [1:0] line_sync_r;
  reg [1:0] line_prev_r;
  reg [31:0] idle_cnt_r;
  reg [31:0] se0_cnt_r;
  // AXI write capture.
  reg aw_held_r;
  reg w_held_r;
  reg [5:0] aw_addr_r;
  reg [7:0] w_byte_r;
  reg w_lane0_r;

  // --------------------------------------------------------------------------
  // AXI write channel
  // --------------------------------------------------------------------------
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held_r | aw_take;
  wire w_have = w_held_r | w_take;
  wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
  wire [5:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  wire [7:0] wr_byte = w_held_r ? w_byte_r : s_axi_wdata[7:0];
  wire wr_lane0 = w_held_r ? w_lane0_r : s_axi_wstrb[0];
  wire wr_ok = (wr_addr == `UNBI_OFF_NAK_EN) || (wr_addr == `UNBI_OFF_NAK_REQ) ||
               (wr_addr == `UNBI_OFF_BUS_EN) || (wr_addr == `UNBI_OFF_BUS_REQ) ||
               (wr_addr == `UNBI_OFF_EP_IN_NAK_EN) || (wr_addr == `UNBI_OFF_EP_IN_NAK_REQ) ||
               (wr_addr == `UNBI_OFF_STATUS);
  wire wr_en = wr_fire & wr_lane0;

  // Address and data may arrive in either order; each is parked until both are here.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 6'h00;
      w_byte_r <= 8'h00;
      w_lane0_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UNBI_RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `UNBI_RESP_OKAY : `UNBI_RESP_SLVERR;
      end
      else
      begin
        if (aw_take)
        begin
          aw_held_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (w_take)
        begin
          w_held_r <= 1'b1;
          w_byte_r <= s_axi_wdata[7:0];
          w_lane0_r <= s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
      // Ready only while the slot is empty and no response is waiting.
      s_axi_awready <= ~aw_have & ~s_axi_bvalid & ~wr_fire & ~s_axi_awready;
      s_axi_wready <= ~w_have & ~s_axi_bvalid & ~wr_fire & ~s_axi_wready;
    end
  end

  // --------------------------------------------------------------------------
  // AXI read channel
  // --------------------------------------------------------------------------
  reg [7:0] rd_byte;
  reg rd_ok;

  // Address decode; unmapped addresses read zero with a slave error.
  always @*
  begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    if (s_axi_araddr == `UNBI_OFF_NAK_EN)
      rd_byte = ping_nak_in_nak_enable_r;
    else if (s_axi_araddr == `UNBI_OFF_NAK_REQ)
      rd_byte = ping_nak_in_nak_request_r;
    else if (s_axi_araddr == `UNBI_OFF_BUS_EN)
      rd_byte = bus_event_enable_r;
    else if (s_axi_araddr == `UNBI_OFF_BUS_REQ)
      rd_byte = bus_event_request_r;
    else if (s_axi_araddr == `UNBI_OFF_EP_IN_NAK_EN)
      rd_byte = per_endpoint_in_nak_enable_r;
    else if (s_axi_araddr == `UNBI_OFF_EP_IN_NAK_REQ)
      rd_byte = per_endpoint_in_nak_request_r;
    else if (s_axi_araddr == `UNBI_OFF_STATUS)
      rd_byte = {5'h00, line_sync_r, high_speed};
    else
      rd_ok = 1'b0;
  end

  // One read at a time; the address is taken only while no data is pending.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `UNBI_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_ok ? `UNBI_RESP_OKAY : `UNBI_RESP_SLVERR;
      end
      else
      begin
        if (s_axi_rvalid && s_axi_rready)
          s_axi_rvalid <= 1'b0;
        s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Endpoint index to bit position
  // --------------------------------------------------------------------------
  // Index 0..5 means endpoint 0,1,2,4,6,8; anything else selects nothing.
  function [5:0] ep_onehot;
    input [2:0] idx;
    begin
      ep_onehot = (idx < 3'h6) ? (6'h01 << idx) : 6'h00;
    end
  endfunction

  wire [5:0] out_sel = ep_onehot(out_ep);
  wire [5:0] in_sel = ep_onehot(in_ep);
  wire out_has_buf = |(out_sel & out_buf_free);
  wire in_is_armed = |(in_sel & in_ep_armed);

  // --------------------------------------------------------------------------
  // Handshake decisions
  // --------------------------------------------------------------------------
  // PING gets ACK once a buffer is free, NAK for as long as none is.
  // An IN token to an unarmed endpoint is NAKed automatically.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hs_ack <= 1'b0;
      hs_nak <= 1'b0;
    end
    else
    begin
      hs_ack <= ping_tok & |out_sel & out_has_buf;
      hs_nak <= (ping_tok & |out_sel & ~out_has_buf) | (in_tok & |in_sel & ~in_is_armed);
    end
  end

  // --------------------------------------------------------------------------
  // Request sources
  // --------------------------------------------------------------------------
  // Ping-NAK requests exist only at high speed, where PING is legal.
  wire ping_nak_evt = (ping_tok | out_tok) & ~out_has_buf & high_speed;
  wire [5:0] ping_set = ping_nak_evt ? out_sel : 6'h00;
  wire [5:0] in_nak_set = (in_tok & ~in_is_armed) ? in_sel : 6'h00;

  // The summary follows only the rise of the enabled OR, so a source that
  // stays pending does not refire after firmware clears the summary.
  wire in_nak_or = |(per_endpoint_in_nak_request_r[5:0] & per_endpoint_in_nak_enable_r[5:0]);
  wire in_nak_rise = in_nak_or & ~in_nak_or_prev_r;

  // --------------------------------------------------------------------------
  // Line state watch
  // --------------------------------------------------------------------------
  wire se0 = (line_sync_r == 2'b00);
  wire line_moved = (line_sync_r != line_prev_r);
  wire suspend_evt = (idle_cnt_r == SUSPEND_CYC - 1);
  wire reset_evt = se0 & (se0_cnt_r == RESET_ONSET_CYC - 1);

  // Two flops before anything looks at the line; counters fire once per episode.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_meta_r <= 2'b00;
      line_sync_r <= 2'b00;
      line_prev_r <= 2'b00;
      idle_cnt_r <= 32'h00000000;
      se0_cnt_r <= 32'h00000000;
    end
    else
    begin
      line_meta_r <= {usb_dp, usb_dm};
      line_sync_r <= line_meta_r;
      line_prev_r <= line_sync_r;
      if (line_moved)
        idle_cnt_r <= 32'h00000000;
      else if (idle_cnt_r < SUSPEND_CYC)
        idle_cnt_r <= idle_cnt_r + 32'h00000001;
      if (!se0)
        se0_cnt_r <= 32'h00000000;
      else if (se0_cnt_r < RESET_ONSET_CYC)
        se0_cnt_r <= se0_cnt_r + 32'h00000001;
    end
  end

  wire [7:0] bus_set = {1'b0,
                        ctrl_status_done,
                        hs_grant,
                        reset_evt,
                        suspend_evt,
                        setup_tok,
                        sof_pkt,
                        setup_bytes_stored};

  // --------------------------------------------------------------------------
  // Write-one-to-clear masks
  // --------------------------------------------------------------------------
  // Only bits written as one are cleared; firmware must not write pending bits back.
  wire [7:0] nak_clr = (wr_en && wr_addr == `UNBI_OFF_NAK_REQ) ? wr_byte : 8'h00;
  wire [7:0] bus_clr = (wr_en && wr_addr == `UNBI_OFF_BUS_REQ) ? wr_byte : 8'h00;
  wire [7:0] in_nak_clr = (wr_en && wr_addr == `UNBI_OFF_EP_IN_NAK_REQ) ? wr_byte : 8'h00;
  wire [7:0] nak_set = {ping_set, 1'b0, in_nak_rise};

  // --------------------------------------------------------------------------
  // Enable and request registers
  // --------------------------------------------------------------------------
  // Set beats clear in the same cycle so no event is lost; all requests but the summary bit 0 ignore enables.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ping_nak_in_nak_enable_r <= `UNBI_RST_EN;
      bus_event_enable_r <= `UNBI_RST_EN;
      per_endpoint_in_nak_enable_r <= `UNBI_RST_EN;
      ping_nak_in_nak_request_r <= `UNBI_RST_REQ;
      bus_event_request_r <= `UNBI_RST_REQ;
      per_endpoint_in_nak_request_r <= `UNBI_RST_REQ;
      in_nak_or_prev_r <= 1'b0;
    end
    else
    begin
      if (wr_en && wr_addr == `UNBI_OFF_NAK_EN)
        ping_nak_in_nak_enable_r <= wr_byte & `UNBI_NAK_MASK;
      if (wr_en && wr_addr == `UNBI_OFF_BUS_EN)
        bus_event_enable_r <= wr_byte & `UNBI_BUS_MASK;
      if (wr_en && wr_addr == `UNBI_OFF_EP_IN_NAK_EN)
        per_endpoint_in_nak_enable_r <= wr_byte & `UNBI_EP_IN_NAK_MASK;
      ping_nak_in_nak_request_r <= ((ping_nak_in_nak_request_r & ~nak_clr) | nak_set) & `UNBI_NAK_MASK;
      bus_event_request_r <= ((bus_event_request_r & ~bus_clr) | bus_set) & `UNBI_BUS_MASK;
      per_endpoint_in_nak_request_r <= ((per_endpoint_in_nak_request_r & ~in_nak_clr) | {2'b00, in_nak_set})
                                       & `UNBI_EP_IN_NAK_MASK;
      in_nak_or_prev_r <= in_nak_or;
    end
  end

  // --------------------------------------------------------------------------
  // Shared interrupt
  // --------------------------------------------------------------------------
  // The ping-NAK enables are honoured only at high speed.
  wire [7:0] nak_live_en = high_speed ? ping_nak_in_nak_enable_r
                                      : (ping_nak_in_nak_enable_r & 8'h01);
  // Registered so the line cannot glitch while requests and enables change.
  always @(posedge aclk)
  begin
    if (!aresetn)
      usb_interrupt_line <= 1'b0;
    else
      usb_interrupt_line <= |(ping_nak_in_nak_request_r & nak_live_en) |
                            |(bus_event_request_r & bus_event_enable_r);
  end
endmodule

/* hdl/unbi_map.vh */
// Register map, field positions, reset values and timing figures of the
// USB NAK and bus-event interrupt block.
// Assumes byte addressing on a 32-bit AXI4-Lite bus with one word per register.
`ifndef UNBI_MAP_VH
`define UNBI_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define UNBI_OFF_NAK_EN 6'h00
`define UNBI_OFF_NAK_REQ 6'h04
`define UNBI_OFF_BUS_EN 6'h08
`define UNBI_OFF_BUS_REQ 6'h0c
`define UNBI_OFF_EP_IN_NAK_EN 6'h10
`define UNBI_OFF_EP_IN_NAK_REQ 6'h14
`define UNBI_OFF_STATUS 6'h18

// ----------------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------------
`define UNBI_NAK_PING_LSB 2
`define UNBI_NAK_SUMMARY_BIT 0
`define UNBI_NAK_MASK 8'hfd
`define UNBI_BUS_MASK 8'h7f
`define UNBI_EP_IN_NAK_MASK 8'h3f
`define UNBI_BUS_STATUS_DONE 6
`define UNBI_BUS_HS_GRANT 5
`define UNBI_BUS_RESET 4
`define UNBI_BUS_SUSPEND 3
`define UNBI_BUS_SETUP_TOK 2
`define UNBI_BUS_SOF 1
`define UNBI_BUS_SETUP_DATA 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define UNBI_RST_EN 8'h00
`define UNBI_RST_REQ 8'h00

// ----------------------------------------------------------------------------
// Timing: the clock period and the line-state times, in nanoseconds
// ----------------------------------------------------------------------------
`define UNBI_CLK_NS 8
`define UNBI_SUSPEND_NS 3000000
`define UNBI_RESET_ONSET_NS 2500
`define UNBI_SUSPEND_CYC (`UNBI_SUSPEND_NS / `UNBI_CLK_NS)
`define UNBI_RESET_ONSET_CYC ((`UNBI_RESET_ONSET_NS + `UNBI_CLK_NS - 1) / `UNBI_CLK_NS)

// ----------------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------------
`define UNBI_RESP_OKAY 2'b00
`define UNBI_RESP_SLVERR 2'b10

`endif

/* testbench/unbi_irq_monitor.sv */
// Concurrent checks on the ports of the NAK and bus-event interrupt block.
// Assumes one clock, aclk, and a synchronous active-low reset, aresetn.
`timescale 1ns/1ps
module unbi_irq_monitor #(
  parameter SUSPEND_CYC = 50,
  parameter RESET_ONSET_CYC = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic ping_tok,
  input wire logic in_tok,
  input wire logic [2:0] out_ep,
  input wire logic [2:0] in_ep,
  input wire logic [5:0] out_buf_free,
  input wire logic [5:0] in_ep_armed,
  input wire logic hs_ack,
  input wire logic hs_nak,
  input wire logic usb_interrupt_line
);
  // --------------------------------------------------------------------
  // Handshake and interrupt properties
  // --------------------------------------------------------------------
  // Indices 6 and 7 are ignored by the block, so they are kept out here.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_PING_NAK: assert property (ping_tok && out_ep < 3'h6 && !out_buf_free[out_ep] |=> hs_nak && !hs_ack)
    else $error("PING without buffer not refused");
  AST_PING_ACK: assert property (ping_tok && out_ep < 3'h6 && out_buf_free[out_ep] |=> hs_ack && !hs_nak)
    else $error("PING with buffer not accepted");
  AST_IN_NAK: assert property (in_tok && in_ep < 3'h6 && !in_ep_armed[in_ep] |=> hs_nak)
    else $error("IN to unarmed endpoint not refused");
  AST_ACK_CAUSE: assert property (hs_ack |-> $past(ping_tok))
    else $error("accept without a PING");
  AST_NAK_CAUSE: assert property (hs_nak |-> $past(ping_tok) || $past(in_tok))
    else $error("refusal without a token");
  AST_IRQ_RST: assert property ($rose(aresetn) |-> !usb_interrupt_line [*3])
    else $error("interrupt high with enables cleared");
  // A response must wait, unchanged, for the master to take it.
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule

bind unbi_irq unbi_irq_monitor #(.SUSPEND_CYC(SUSPEND_CYC), .RESET_ONSET_CYC(RESET_ONSET_CYC)) u_mon (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .ping_tok, .in_tok, .out_ep, .in_ep, .out_buf_free, .in_ep_armed, .hs_ack,
  .hs_nak, .usb_interrupt_line);

/* testbench/unbi_host_model.sv */
// Host-side model: tokens, bus events and the D+/D- line state.
// Assumes the block answers a token one cycle after taking it.
`timescale 1ns/1ps
module unbi_host_model (
  input wire logic aclk,
  input wire logic hs_ack,
  input wire logic hs_nak,
  output logic ping_tok,
  output logic out_tok,
  output logic in_tok,
  output logic [2:0] ep,
  output logic [4:0] evt,
  output logic usb_dp,
  output logic usb_dm
);
  logic [1:0] mode;
  logic [3:0] cnt;
  // --------------------------------------------------------------------
  // Line state
  // --------------------------------------------------------------------
  // Mode 0 toggles J and K every 16 cycles so suspend never fires by itself.
  initial
  begin
    {ping_tok, out_tok, in_tok, ep, evt, mode, cnt} = 0;
    {usb_dp, usb_dm} = 2'b10;
  end
  always @(posedge aclk)
  begin
    cnt <= cnt + 4'h1;
    if (mode == 2'd2)
      {usb_dp, usb_dm} <= 2'b00; // SE0 is the reset signalling.
    else if (mode == 2'd1)
      {usb_dp, usb_dm} <= 2'b10; // Idle J with no activity.
    else if (cnt == 4'h0)
      {usb_dp, usb_dm} <= {~usb_dp, usb_dp};
  end
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  // Kind 0 is PING, 1 is OUT, 2 is IN; the answer is {ack, nak}.
  task tok(input [1:0] kind, input [2:0] idx, output [1:0] ans);
    @(posedge aclk);
    ep <= idx;
    ping_tok <= kind == 2'd0;
    out_tok <= kind == 2'd1;
    in_tok <= kind == 2'd2;
    @(posedge aclk);
    {ping_tok, out_tok, in_tok} <= 3'b000;
    @(posedge aclk);
    ans = {hs_ack, hs_nak};
  endtask
  task ev(input int k);
    @(posedge aclk);
    evt <= 5'h01 << k;
    @(posedge aclk);
    evt <= 5'h00;
  endtask
  task line(input [1:0] m);
    mode <= m;
  endtask
endmodule

/* testbench/test_unbi_irq.sv */
// Self-checking bench for the NAK and bus-event interrupt block.
// Assumes the host model file and the bound checker are compiled first.
`timescale 1ns/1ps
module test_unbi_irq;
  localparam SUS = 50;
  localparam RON = 8;
  logic aclk = 0;
  logic aresetn = 0;
  logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic high_speed = 0;
  logic [5:0] out_buf_free = 0, in_ep_armed = 0;
  wire ping_tok, out_tok, in_tok, usb_dp, usb_dm, hs_ack, hs_nak, usb_interrupt_line;
  wire ctrl_status_done, hs_grant, setup_tok, sof_pkt, setup_bytes_stored;
  wire [2:0] ep;
  int error_cnt = 0, n_tests = 0;
  logic [1:0] ans, rr;
  logic [31:0] rv;
  int eb[5] = '{0, 1, 2, 5, 6};
  // --------------------------------------------------------------------
  // Design, host model and clock
  // --------------------------------------------------------------------
  // Short line-state counts keep the suspend and reset waits brief.
  unbi_irq #(.SUSPEND_CYC(SUS), .RESET_ONSET_CYC(RON)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .high_speed, .ping_tok, .out_tok,
    .out_ep(ep), .out_buf_free, .in_tok, .in_ep(ep), .in_ep_armed, .ctrl_status_done, .hs_grant,
    .setup_tok, .sof_pkt, .setup_bytes_stored, .usb_dp, .usb_dm, .hs_ack, .hs_nak, .usb_interrupt_line);
  unbi_host_model host (.aclk, .hs_ack, .hs_nak, .ping_tok, .out_tok, .in_tok, .ep, .usb_dp, .usb_dm,
    .evt({ctrl_status_done, hs_grant, setup_tok, sof_pkt, setup_bytes_stored}));
  always #4 aclk = ~aclk;
  // --------------------------------------------------------------------
  // Bus tasks and checks
  // --------------------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data go out together; each is dropped once taken.
  task wr(input [5:0] a, input [7:0] d);
    logic aw, w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw = 0;
    w = 0;
    while (!(aw && w))
    begin
      @(posedge aclk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    // One late cycle on bready proves the response waits.
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [5:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task rdc(input [5:0] a, input [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial
  begin
    #100000;
    error_cnt++;
    end_sim;
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(6'h00, 0);
    rdc(6'h08, 0);
    rdc(6'h10, 0);
    wr(6'h00, 8'hff);
    rdc(6'h00, 32'hfd);
    wr(6'h08, 8'hff);
    rdc(6'h08, 32'h7f);
    wr(6'h10, 8'hff);
    rdc(6'h10, 32'h3f);
    wr(6'h00, 8'h00);
    wr(6'h08, 8'h00);
    wr(6'h1c, 8'hff);
    chk(rr, 2'b10);
    rdc(6'h1c, 0);
    chk(rr, 2'b10);
    $display("test registers done");
    // Each event sets its bit while disabled; the line stays low.
    for (int k = 0; k < 5; k++)
    begin
      host.ev(k);
      rdc(6'h0c, 32'h1 << eb[k]);
      chk(usb_interrupt_line, 0);
      wr(6'h0c, 8'h1 << eb[k]);
      rdc(6'h0c, 0);
    end
    host.ev(4);
    host.ev(0);
    wr(6'h0c, 8'h01);
    rdc(6'h0c, 32'h40);
    wr(6'h08, 8'h40);
    chk(usb_interrupt_line, 1);
    wr(6'h0c, 8'h40);
    rdc(6'h0c, 0);
    chk(usb_interrupt_line, 0);
    wr(6'h08, 8'h00);
    $display("test bus events done");
    high_speed <= 1'b1;
    host.tok(0, 3, ans);
    chk(ans, 2'b01);
    host.tok(0, 3, ans);
    chk(ans, 2'b01);
    rdc(6'h04, 32'h20);
    out_buf_free <= 6'h08;
    host.tok(0, 3, ans);
    chk(ans, 2'b10);
    // Index 6 names no endpoint, so the PING gets no answer at all.
    host.tok(0, 6, ans);
    chk(ans, 2'b00);
    host.tok(1, 0, ans);
    rdc(6'h04, 32'h24);
    wr(6'h04, 8'h20);
    rdc(6'h04, 32'h04);
    high_speed <= 1'b0;
    host.tok(0, 1, ans);
    chk(ans, 2'b01);
    rdc(6'h04, 32'h04);
    wr(6'h00, 8'h04);
    chk(usb_interrupt_line, 0);
    high_speed <= 1'b1;
    rd(6'h04);
    chk(usb_interrupt_line, 1);
    wr(6'h04, 8'h04);
    $display("test ping done");
    // The summary must not fire again while another endpoint keeps the OR high.
    wr(6'h00, 8'h01);
    in_ep_armed <= 6'h2d;
    host.tok(2, 1, ans);
    chk(ans, 2'b01);
    rdc(6'h14, 32'h02);
    rdc(6'h04, 32'h01);
    chk(usb_interrupt_line, 1);
    wr(6'h04, 8'h01);
    host.tok(2, 4, ans);
    rdc(6'h14, 32'h12);
    rdc(6'h04, 0);
    wr(6'h14, 8'h12);
    host.tok(2, 4, ans);
    rdc(6'h04, 32'h01);
    wr(6'h04, 8'h01);
    wr(6'h00, 8'h00);
    $display("test in nak done");
    host.line(2);
    repeat (RON + 4) @(posedge aclk);
    rdc(6'h0c, 32'h10);
    host.line(1);
    repeat (SUS - 20) @(posedge aclk);
    rdc(6'h0c, 32'h10);
    repeat (30) @(posedge aclk);
    rdc(6'h0c, 32'h18);
    rdc(6'h18, 32'h05);
    host.line(0);
    wr(6'h0c, 8'h18);
    rdc(6'h0c, 0);
    $display("test line state done");
    end_sim;
  end
endmodule
